/* src/pwmotf_pkg.sv */
// Package for the PWM output, trigger and fault control block.
// Assumes a 32-bit APB slave with one register per aligned word.
package pwmotf_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_ALT_DT   = 8'h00;
  localparam logic [7:0] ADDR_TRG_CTL  = 8'h04;
  localparam logic [7:0] ADDR_PIN_CTL  = 8'h08;
  localparam logic [7:0] ADDR_TRG_CMP  = 8'h0c;
  localparam logic [7:0] ADDR_FLT_CTL  = 8'h10;
  localparam logic [7:0] ADDR_MOD_CTL  = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam int         NUM_REGS      = 7;

  // Write masks, implemented bits only
  localparam logic [15:0] MASK_ALT_DT  = 16'h3fff;
  localparam logic [15:0] MASK_TRG_CTL = 16'hf0bf;
  localparam logic [15:0] MASK_PIN_CTL = 16'hffff;
  localparam logic [15:0] MASK_TRG_CMP = 16'hfff8;
  localparam logic [15:0] MASK_FLT_CTL = 16'hffff;
  localparam logic [15:0] MASK_MOD_CTL = 16'h0001;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // Trigger control fields
  localparam int TRG_DIV_LSB   = 12;
  localparam int TRG_DUAL_BIT  = 7;
  localparam int TRG_START_LSB = 0;

  // Pin control fields
  localparam int PIN_OWN_H     = 15;
  localparam int PIN_OWN_L     = 14;
  localparam int PIN_POL_H     = 13;
  localparam int PIN_POL_L     = 12;
  localparam int PIN_MODE_LSB  = 10;
  localparam int PIN_OVR_EN_H  = 9;
  localparam int PIN_OVR_EN_L  = 8;
  localparam int PIN_OVR_LSB   = 6;
  localparam int PIN_FLT_LSB   = 4;
  localparam int PIN_CL_LSB    = 2;
  localparam int PIN_SWAP      = 1;
  localparam int PIN_OVERRIDE_SYNCHRONISATION     = 0;

  // Fault and current-limit fields
  localparam int FLT_INDEP     = 15;
  localparam int FLT_CL_SRC    = 10;
  localparam int FLT_CL_POL    = 9;
  localparam int FLT_CL_EN     = 8;
  localparam int FLT_SRC_LSB   = 3;
  localparam int FLT_POL       = 2;
  localparam int FLT_MODE_LSB  = 0;

  // Source encodings
  localparam logic [4:0] SRC_CMP_LAST   = 5'h03;
  localparam logic [4:0] SRC_FAULT_BASE = 5'h08;
  localparam logic [4:0] SRC_FAULT_LAST = 5'h1e;
  localparam int         NUM_CMP        = 4;
  localparam int         NUM_FAULT      = 23;

  typedef enum logic [1:0] {
    PWMOTF_MODE_COMPL  = 2'b00,
    PWMOTF_MODE_REDUND = 2'b01,
    PWMOTF_MODE_PUSH   = 2'b10,
    PWMOTF_MODE_INDEP  = 2'b11
  } pwmotf_mode_e;

  typedef enum logic [1:0] {
    PWMOTF_FLT_LATCH = 2'b00,
    PWMOTF_FLT_CYCLE = 2'b01,
    PWMOTF_FLT_RSVD  = 2'b10,
    PWMOTF_FLT_OFF   = 2'b11
  } pwmotf_fmode_e;

  // Start delay states, Gray along the path
  typedef enum logic [1:0] {
    PWMOTF_ST_IDLE = 2'b00,
    PWMOTF_ST_WAIT = 2'b01,
    PWMOTF_ST_RUN  = 2'b11
  } pwmotf_st_e;

endpackage

/* src/pwmotf_sync.sv */
// Two-stage synchroniser bank for asynchronous inputs.
// Assumes inputs are levels from outside the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module pwmotf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* src/pwmotf_top.sv */
// PWM generator output stage, ADC trigger logic and fault selection.
// Assumes APB master on pclk; raw PWM, time base and trigger events
// come from same-clock logic, fault and comparator inputs from pins.
`timescale 1ns/100ps
`default_nettype none
module pwmotf_top
  import pwmotf_pkg::*;
#(
  parameter int DIV_W   = 4,
  parameter int START_W = 6
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // PWM core signals, same clock
  input  wire logic        raw_high,
  input  wire logic        raw_low,
  input  wire logic        cycle_start,
  input  wire logic        local_tb,
  input  wire logic [15:0] tb_count,
  input  wire logic        sec_trig_event,
  // Asynchronous pin inputs
  input  wire logic [pwmotf_pkg::NUM_CMP-1:0]   cmp_in,
  input  wire logic [pwmotf_pkg::NUM_FAULT-1:0] fault_in,
  // Pins and triggers
  output logic             high_side_output,
  output logic             high_side_oe,
  output logic             low_side_output,
  output logic             low_side_oe,
  output logic             adc_trigger,
  output logic             sec_adc_trigger,
  output logic             dead_time_compensation_input
);
  import pwmotf_pkg::*;

  typedef struct packed {
    logic [15:0]        alt_dt;
    logic [15:0]        trg_ctl;
    logic [15:0]        pin_ctl;
    logic [15:0]        trg_cmp;
    logic [15:0]        flt_ctl;
    logic               enable;
    logic [31:0]        rdata;
    logic               ready;
    logic               slverr;
    pwmotf_st_e         st;
    logic [START_W-1:0] start_cnt;
    logic [DIV_W-1:0]   div_cnt;
    logic [1:0]         ovr_act;
    logic               flt_latched;
    logic               high_o;
    logic               low_o;
    logic               high_oe;
    logic               low_oe;
    logic               trig;
    logic               sec_trig;
    logic               dtc;
  } pwmotf_state_s;

  pwmotf_state_s cur_ff;
  pwmotf_state_s nxt_cur;

  logic [NUM_CMP+NUM_FAULT-1:0] src_sync;

  pwmotf_sync #(
    .WIDTH (NUM_CMP + NUM_FAULT)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({fault_in, cmp_in}),
    .sync_out (src_sync)
  );

  // Decode of a source select code to a raw level; reserved reads low
  function automatic logic pick_src(input logic [4:0] sel,
                                    input logic [NUM_CMP+NUM_FAULT-1:0] src);
    logic r;
    r = 1'b0;
    if (sel <= SRC_CMP_LAST) begin
      r = src[sel];
    end else if (sel >= SRC_FAULT_BASE && sel <= SRC_FAULT_LAST) begin
      r = src[NUM_CMP + 5'(sel - SRC_FAULT_BASE)];
    end
    return r;
  endfunction

  function automatic logic [15:0] wmask(input logic [7:0] a);
    logic [15:0] m;
    m = 16'h0000;
    case (a)
      ADDR_ALT_DT:  m = MASK_ALT_DT;
      ADDR_TRG_CTL: m = MASK_TRG_CTL;
      ADDR_PIN_CTL: m = MASK_PIN_CTL;
      ADDR_TRG_CMP: m = MASK_TRG_CMP;
      ADDR_FLT_CTL: m = MASK_FLT_CTL;
      ADDR_MOD_CTL: m = MASK_MOD_CTL;
      default:      m = 16'h0000;
    endcase
    return m;
  endfunction

  logic              apb_wr;
  logic              apb_rd;
  logic              addr_ok;
  logic              flt_raw;
  logic              cl_raw;
  logic              flt_act;
  logic              cl_act;
  logic              indep;
  logic              trig_ev;
  logic              pri_match;
  logic [1:0]        ovr_d;
  logic [1:0]        sig;
  logic              pol_h;
  logic              pol_l;
  logic [15:0]       wd;
  pwmotf_mode_e      omode;
  pwmotf_fmode_e     fmode;

  always_comb begin
    nxt_cur = cur_ff;
    wd      = pwdata[15:0];
    addr_ok = (paddr[7:0] <= ADDR_STATUS) && (paddr[1:0] == 2'b00);
    // Write lands at the access edge where pready is seen high
    apb_wr  = psel && penable && pwrite && cur_ff.ready;
    apb_rd  = psel && !penable && !pwrite;

    // Fault and current-limit source selection with polarity
    cl_raw  = pick_src(cur_ff.flt_ctl[FLT_CL_SRC +: 5], src_sync);
    flt_raw = pick_src(cur_ff.flt_ctl[FLT_SRC_LSB +: 5], src_sync);
    cl_act  = cl_raw ^ cur_ff.flt_ctl[FLT_CL_POL];
    flt_act = flt_raw ^ cur_ff.flt_ctl[FLT_POL];
    nxt_cur.dtc = cl_act;
    indep   = cur_ff.flt_ctl[FLT_INDEP];
    fmode   = pwmotf_fmode_e'(cur_ff.flt_ctl[FLT_MODE_LSB +: 2]);

    // APB: answer one cycle after setup, pready high in access phase
    nxt_cur.ready  = psel && !penable;
    nxt_cur.slverr = psel && !penable && !addr_ok;
    if (apb_wr && addr_ok) begin
      case (paddr)
        ADDR_ALT_DT:  nxt_cur.alt_dt  = wd & wmask(paddr);
        ADDR_TRG_CTL: nxt_cur.trg_ctl = wd & wmask(paddr);
        ADDR_PIN_CTL: nxt_cur.pin_ctl = wd & wmask(paddr);
        ADDR_TRG_CMP: nxt_cur.trg_cmp = wd & wmask(paddr);
        ADDR_FLT_CTL: nxt_cur.flt_ctl = wd & wmask(paddr);
        ADDR_MOD_CTL: nxt_cur.enable  = wd[0];
        default:      nxt_cur.enable  = cur_ff.enable;
      endcase
    end
    nxt_cur.rdata = 32'h0000_0000;
    if (apb_rd && addr_ok) begin
      case (paddr)
        ADDR_ALT_DT:  nxt_cur.rdata = {16'h0000, cur_ff.alt_dt};
        ADDR_TRG_CTL: nxt_cur.rdata = {16'h0000, cur_ff.trg_ctl};
        ADDR_PIN_CTL: nxt_cur.rdata = {16'h0000, cur_ff.pin_ctl};
        ADDR_TRG_CMP: nxt_cur.rdata = {16'h0000, cur_ff.trg_cmp};
        ADDR_FLT_CTL: nxt_cur.rdata = {16'h0000, cur_ff.flt_ctl};
        ADDR_MOD_CTL: nxt_cur.rdata = {31'h0000_0000, cur_ff.enable};
        ADDR_STATUS:  nxt_cur.rdata = {24'h00_0000, 2'(cur_ff.st),
                                       cur_ff.dtc, cur_ff.flt_latched,
                                       cl_act, flt_act,
                                       cur_ff.high_o, cur_ff.low_o};
        default:      nxt_cur.rdata = 32'h0000_0000;
      endcase
    end

    // Latched fault clears only at a cycle boundary with the fault gone
    case (fmode)
      PWMOTF_FLT_LATCH: begin
        if (flt_act) begin
          nxt_cur.flt_latched = 1'b1;
        end else if (cycle_start) begin
          nxt_cur.flt_latched = 1'b0;
        end
      end
      PWMOTF_FLT_CYCLE: nxt_cur.flt_latched = flt_act;
      default:          nxt_cur.flt_latched = 1'b0;
    endcase

    // Trigger: compare, dual merge, start delay, postscaler
    pri_match = local_tb && (tb_count[15:3] == cur_ff.trg_cmp[15:3]);
    trig_ev   = pri_match || (cur_ff.trg_ctl[TRG_DUAL_BIT] && sec_trig_event);
    nxt_cur.trig     = 1'b0;
    nxt_cur.sec_trig = 1'b0;
    case (cur_ff.st)
      PWMOTF_ST_IDLE: begin
        nxt_cur.div_cnt   = '0;
        nxt_cur.start_cnt = cur_ff.trg_ctl[TRG_START_LSB +: START_W];
        if (cur_ff.enable) begin
          nxt_cur.st = PWMOTF_ST_WAIT;
        end
      end
      PWMOTF_ST_WAIT: begin
        if (cur_ff.start_cnt == '0) begin
          nxt_cur.st = PWMOTF_ST_RUN;
        end else if (cycle_start) begin
          nxt_cur.start_cnt = cur_ff.start_cnt - 1'b1;
        end
      end
      PWMOTF_ST_RUN: begin
        if (trig_ev) begin
          if (cur_ff.div_cnt == cur_ff.trg_ctl[TRG_DIV_LSB +: DIV_W]) begin
            nxt_cur.div_cnt = '0;
            nxt_cur.trig    = 1'b1;
          end else begin
            nxt_cur.div_cnt = cur_ff.div_cnt + 1'b1;
          end
        end
        nxt_cur.sec_trig = sec_trig_event && !cur_ff.trg_ctl[TRG_DUAL_BIT];
      end
      default: nxt_cur.st = PWMOTF_ST_IDLE;
    endcase
    if (!cur_ff.enable) begin
      nxt_cur.st = PWMOTF_ST_IDLE;
    end

    // Override data update timing
    if (!cur_ff.pin_ctl[PIN_OVERRIDE_SYNCHRONISATION] || cycle_start) begin
      nxt_cur.ovr_act = cur_ff.pin_ctl[PIN_OVR_LSB +: 2];
    end

    // Output mode shaping, logical states
    omode = pwmotf_mode_e'(cur_ff.pin_ctl[PIN_MODE_LSB +: 2]);
    case (omode)
      PWMOTF_MODE_COMPL:  sig = {raw_high, !raw_high};
      PWMOTF_MODE_REDUND: sig = {raw_high, raw_high};
      PWMOTF_MODE_PUSH:   sig = {raw_high && !cur_ff.div_cnt[0],
                                 raw_high && cur_ff.div_cnt[0]};
      PWMOTF_MODE_INDEP:  sig = {raw_high, raw_low};
      default:            sig = {raw_high, raw_low};
    endcase

    // Current limit, normal or independent fault handling
    if (cur_ff.flt_ctl[FLT_CL_EN] && cl_act) begin
      if (!indep) begin
        sig = cur_ff.pin_ctl[PIN_CL_LSB +: 2];
      end else begin
        sig[1] = cur_ff.pin_ctl[PIN_FLT_LSB + 1];
      end
    end
    if (cur_ff.flt_latched) begin
      if (!indep) begin
        sig = cur_ff.pin_ctl[PIN_FLT_LSB +: 2];
      end else begin
        sig[0] = cur_ff.pin_ctl[PIN_FLT_LSB];
      end
    end

    // Override has top priority per pin
    ovr_d = cur_ff.ovr_act;
    if (cur_ff.pin_ctl[PIN_OVR_EN_H]) begin
      sig[1] = ovr_d[1];
    end
    if (cur_ff.pin_ctl[PIN_OVR_EN_L]) begin
      sig[0] = ovr_d[0];
    end

    // Swap then polarity to pin levels
    if (cur_ff.pin_ctl[PIN_SWAP]) begin
      sig = {sig[0], sig[1]};
    end
    pol_h = cur_ff.pin_ctl[PIN_POL_H];
    pol_l = cur_ff.pin_ctl[PIN_POL_L];
    nxt_cur.high_o  = sig[1] ^ pol_h;
    nxt_cur.low_o   = sig[0] ^ pol_l;
    nxt_cur.high_oe = cur_ff.pin_ctl[PIN_OWN_H];
    nxt_cur.low_oe  = cur_ff.pin_ctl[PIN_OWN_L];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{alt_dt: REG_RESET, trg_ctl: REG_RESET, pin_ctl: REG_RESET,
                  trg_cmp: REG_RESET, flt_ctl: REG_RESET, enable: 1'b0,
                  rdata: 32'h0000_0000, ready: 1'b0, slverr: 1'b0,
                  st: PWMOTF_ST_IDLE, start_cnt: '0, div_cnt: '0,
                  ovr_act: 2'b00, flt_latched: 1'b0, high_o: 1'b0,
                  low_o: 1'b0, high_oe: 1'b0, low_oe: 1'b0, trig: 1'b0,
                  sec_trig: 1'b0, dtc: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata                       = cur_ff.rdata;
  assign pready                       = cur_ff.ready;
  assign pslverr                      = cur_ff.slverr;
  assign high_side_output             = cur_ff.high_o;
  assign high_side_oe                 = cur_ff.high_oe;
  assign low_side_output              = cur_ff.low_o;
  assign low_side_oe                  = cur_ff.low_oe;
  assign adc_trigger                  = cur_ff.trig;
  assign sec_adc_trigger              = cur_ff.sec_trig;
  assign dead_time_compensation_input = cur_ff.dtc;
endmodule
`default_nettype wire

/* bench/pwmotf_chk_sva.sv */
// Checker for pwmotf_top: APB answer, register masks, pin stage.
// Assumes it is bound to every pwmotf_top instance.
`timescale 1ns/100ps
`default_nettype none
module pwmotf_chk
  import pwmotf_pkg::*;
#(
  parameter int DIV_W   = 4,
  parameter int START_W = 6
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Core side and pins
  input  wire logic        raw_high,
  input  wire logic        raw_low,
  input  wire logic        cycle_start,
  input  wire logic        sec_adc_trigger,
  input  wire logic        high_side_output,
  input  wire logic        low_side_output
);
  logic [15:0] pin_ff;
  logic [15:0] flt_ff;
  logic        dual_ff;
  logic        wr;

  assign wr = psel && penable && pwrite && pready;

  // Shadow copies of pin and fault control and the trigger dual bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff  <= '0;
      flt_ff  <= '0;
      dual_ff <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_PIN_CTL) pin_ff <= pwdata[15:0];
      if (wr && paddr == ADDR_FLT_CTL) flt_ff <= pwdata[15:0];
      if (wr && paddr == ADDR_TRG_CTL) dual_ff <= pwdata[TRG_DUAL_BIT];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_steady;
    pin_ff == $past(pin_ff) && pin_ff == $past(pin_ff, 2) &&
    flt_ff == $past(flt_ff) && flt_ff == $past(flt_ff, 2);
  endsequence

  AST_READY_AFTER_SETUP: assert property (s_setup |=> pready)
    else $error("no pready after setup");
  AST_READY_SINGLE: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  AST_UNMAPPED_ERR: assert property (s_setup ##0 (paddr > ADDR_STATUS || paddr[1:0] != 2'b00)
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  AST_ALT_DT_UPPER: assert property (s_rd(ADDR_ALT_DT) |=> prdata[31:14] == '0)
    else $error("dead time upper bits set");
  AST_TRG_CMP_LOW: assert property (s_rd(ADDR_TRG_CMP) |=> prdata[2:0] == 3'b000)
    else $error("compare low bits set");
  AST_DUAL_NO_SEC: assert property (dual_ff && $past(dual_ff) |-> !sec_adc_trigger)
    else $error("separate trigger while merged");
  AST_OVR_DRIVES: assert property (pin_ff[9:8] == 2'b11 && pin_ff[1:0] == 2'b00 ##0 s_steady
    |-> high_side_output == (pin_ff[7] ^ pin_ff[13]) && low_side_output == (pin_ff[6] ^ pin_ff[12]))
    else $error("override level wrong");
  AST_SWAP: assert property (pin_ff[13:12] == 2'b00 && pin_ff[9:8] == 2'b11 &&
    pin_ff[1:0] == 2'b10 ##0 s_steady
    |-> high_side_output == pin_ff[6] && low_side_output == pin_ff[7]) else $error("swap wrong");
  AST_OVERRIDE_SYNCHRONISATION_HOLD: assert property (pin_ff[9:8] == 2'b11 && pin_ff[0] && !$past(cycle_start) &&
    !$past(cycle_start, 2) ##0 s_steady |-> $stable(high_side_output) && $stable(low_side_output))
    else $error("override moved between boundaries");
  AST_FAULT_OFF_PASS: assert property (flt_ff[8:0] == 9'h003 && pin_ff[13:8] == 6'h0c &&
    !pin_ff[1] ##0 s_steady |-> high_side_output == $past(raw_high) && low_side_output == $past(raw_low))
    else $error("independent pins do not follow raw");
endmodule
bind pwmotf_top pwmotf_chk #(.DIV_W(DIV_W), .START_W(START_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_high(raw_high), .raw_low(raw_low), .cycle_start(cycle_start),
  .sec_adc_trigger(sec_adc_trigger), .high_side_output(high_side_output),
  .low_side_output(low_side_output));
`default_nettype wire

/* bench/pwmotf_stage.sv */
// Model of the sense lines and ADC trigger input beside pwmotf_top.
// Assumes the bench names one source to trip and the lines' active level.
`timescale 1ns/100ps
`default_nettype none
module pwmotf_stage
  import pwmotf_pkg::*;
(
  // Clock and trip request
  input  wire logic                             pclk,
  input  wire logic                             trip,
  input  wire logic                             act_low,
  input  wire logic [4:0]                       trip_src,
  // Sense lines and triggers
  output logic      [pwmotf_pkg::NUM_CMP-1:0]   cmp_in,
  output logic      [pwmotf_pkg::NUM_FAULT-1:0] fault_in,
  input  wire logic                             adc_trigger,
  input  wire logic                             sec_adc_trigger,
  output int                                    trig_cnt,
  output int                                    sec_cnt
);
  // Idle lines sit at the inactive level
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) cmp_in[i] = act_low ^ (trip && trip_src == 5'(i));
    for (int i = 0; i < NUM_FAULT; i++) fault_in[i] = act_low ^ (trip && trip_src == SRC_FAULT_BASE + 5'(i));
  end
  initial begin
    trig_cnt = 0;
    sec_cnt = 0;
  end
  always @(posedge pclk) begin
    if (adc_trigger === 1'b1) trig_cnt <= trig_cnt + 1;
    if (sec_adc_trigger === 1'b1) sec_cnt <= sec_cnt + 1;
  end
endmodule
`default_nettype wire

/* bench/pwmotf_top_test.sv */
// Bench for pwmotf_top: APB registers, pin stage, faults and triggers.
// Assumes the stage model pwmotf_stage on the sense and trigger lines.
`timescale 1ns/100ps
`default_nettype none
module pwmotf_top_test;
  import pwmotf_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, d;
  logic                 raw_high, raw_low, cycle_start, local_tb, sec_trig_event, dtc;
  logic [15:0]          tb_count, cmpv;
  logic                 high_side_output, low_side_output, adc_trigger, sec_adc_trigger;
  logic                 trip, act_low, sw, hoe, loe;
  logic [4:0]           trip_src;
  logic [NUM_CMP-1:0]   cmp_in;
  logic [NUM_FAULT-1:0] fault_in;
  logic [1:0]           m, pol, o, fd, cd;
  logic [33:0]          note;
  logic [33:0]          notes[$];
  logic [7:0]           addrs[6] = '{ADDR_ALT_DT, ADDR_TRG_CTL, ADDR_PIN_CTL, ADDR_TRG_CMP,
                                     ADDR_FLT_CTL, ADDR_MOD_CTL};
  logic [15:0]          masks[6] = '{MASK_ALT_DT, MASK_TRG_CTL, MASK_PIN_CTL, MASK_TRG_CMP,
                                     MASK_FLT_CTL, MASK_MOD_CTL};
  int                   trig_cnt, sec_cnt, n0, n1, cyc, miscompares, samples_checked;

  pwmotf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_high(raw_high), .raw_low(raw_low), .cycle_start(cycle_start),
    .local_tb(local_tb), .tb_count(tb_count), .sec_trig_event(sec_trig_event),
    .cmp_in(cmp_in), .fault_in(fault_in), .high_side_output(high_side_output),
    .high_side_oe(hoe), .low_side_output(low_side_output), .low_side_oe(loe),
    .adc_trigger(adc_trigger), .sec_adc_trigger(sec_adc_trigger),
    .dead_time_compensation_input(dtc));
  pwmotf_stage stage (.pclk(pclk), .trip(trip), .act_low(act_low), .trip_src(trip_src),
    .cmp_in(cmp_in), .fault_in(fault_in), .adc_trigger(adc_trigger),
    .sec_adc_trigger(sec_adc_trigger), .trig_cnt(trig_cnt), .sec_cnt(sec_cnt));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] e);
    notes.push_back({!w, a > ADDR_STATUS || a[1:0] != 2'b00, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pins(input logic [1:0] e);
    chk("pins", {30'h0, e}, {30'h0, high_side_output, low_side_output});
  endtask
  task automatic pulse();
    @(posedge pclk);
    cycle_start <= 1'b1;
    @(posedge pclk);
    cycle_start <= 1'b0;
    tick(5);
  endtask
  task automatic ev(input int k);
    repeat (k) begin
      @(posedge pclk);
      tb_count <= cmpv;
      @(posedge pclk);
      tb_count <= cmpv ^ 16'h8;
      tick(2);
    end
    tick(3);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Read results against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      if (note[33]) chk("prdata", note[31:0], prdata);
    end
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 20000) begin
        miscompares++;
        tally_and_finish();
      end
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, raw_high, raw_low, cycle_start} = '0;
    {local_tb, tb_count, sec_trig_event, trip, act_low, trip_src} = '0;
    presetn = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    d = $urandom(32'hf8c98f09);
    tick(12);
    presetn <= 1'b1;
    foreach (addrs[i]) apb(0, addrs[i], 0, 0);
    apb(0, 8'h1c, 0, 0);
    apb(0, 8'h02, 0, 0);
    apb(1, 8'h20, 32'hffffffff, 0);
    foreach (addrs[i]) begin
      d = $urandom;
      apb(1, addrs[i], d, 0);
      apb(0, addrs[i], 0, {16'h0, d[15:0] & masks[i]});
      if (addrs[i] == ADDR_PIN_CTL) chk("enables", {30'h0, d[15:14]}, {30'h0, hoe, loe});
      apb(1, addrs[i], 0, 0);
    end
    apb(1, ADDR_FLT_CTL, 32'h3, 0);
    for (int i = 0; i < 12; i++) begin
      m = 2'(i % 4);
      pol = 2'($urandom);
      apb(1, ADDR_PIN_CTL, {16'h0, 2'b11, pol, m, 10'h0}, 0);
      @(posedge pclk);
      raw_high <= 1'($urandom);
      raw_low <= 1'($urandom);
      tick(3);
      pins({raw_high, m == 2'b11 ? raw_low : (m == 2'b01 ? raw_high :
            (m == 2'b10 ? 1'b0 : !raw_high))} ^ pol);
    end
    for (int i = 0; i < 4; i++) begin
      o = 2'($urandom);
      sw = i[1];
      pol = sw ? 2'b00 : 2'($urandom);
      apb(1, ADDR_PIN_CTL, {16'h0, 2'b11, pol, 4'hf, o, 4'h0, sw, 1'b0}, 0);
      tick(3);
      pins(sw ? {o[0], o[1]} : o ^ pol);
    end
    apb(1, ADDR_PIN_CTL, 32'hcf80, 0);
    apb(1, ADDR_PIN_CTL, 32'hcf41, 0);
    tick(5);
    pins(2'b10);
    pulse();
    pins(2'b01);
    for (int i = 0; i < 4; i++) begin
      trip_src = i[0] ? 5'($urandom_range(0, 3)) : 5'($urandom_range(8, 30));
      fd = 2'($urandom);
      @(posedge pclk);
      act_low <= 1'($urandom);
      apb(1, ADDR_PIN_CTL, {16'h0, 8'hcc, 2'b00, fd, 4'h0}, 0);
      apb(1, ADDR_FLT_CTL, {16'h0, 6'h1f, 2'b00, trip_src, act_low, 1'b0, i[1]}, 0);
      @(posedge pclk);
      trip <= 1'b1;
      tick(6);
      pins(fd);
      @(posedge pclk);
      trip <= 1'b0;
      tick(6);
      pins(i[1] ? {raw_high, raw_low} : fd);
      pulse();
      pins({raw_high, raw_low});
      apb(1, ADDR_FLT_CTL, 32'h3, 0);
    end
    for (int i = 0; i < 2; i++) begin
      trip_src = 5'($urandom_range(8, 30));
      {fd, cd} = 4'($urandom);
      @(posedge pclk);
      act_low <= 1'($urandom);
      apb(1, ADDR_PIN_CTL, {16'h0, 8'hcc, 2'b00, fd, cd, 2'b00}, 0);
      apb(1, ADDR_FLT_CTL, {16'h0, i[0], trip_src, act_low, 1'b1, 5'h1f, 3'b011}, 0);
      @(posedge pclk);
      trip <= 1'b1;
      tick(6);
      pins(i[0] ? {fd[1], raw_low} : cd);
      chk("dtc", 32'h1, {31'h0, dtc});
      @(posedge pclk);
      trip <= 1'b0;
      tick(6);
      pulse();
      pins({raw_high, raw_low});
      apb(1, ADDR_FLT_CTL, 32'h3, 0);
    end
    cmpv = (16'($urandom) | 16'h0100) & 16'hfff8;
    tb_count <= cmpv ^ 16'h8;
    local_tb <= 1'b1;
    apb(1, ADDR_TRG_CMP, {16'h0, cmpv}, 0);
    apb(1, ADDR_TRG_CTL, 32'h2002, 0);
    apb(1, ADDR_MOD_CTL, 32'h1, 0);
    n0 = trig_cnt;
    ev(3);
    chk("triggers", n0, trig_cnt);
    pulse();
    pulse();
    ev(6);
    chk("triggers", n0 + 2, trig_cnt);
    for (int i = 0; i < 2; i++) begin
      apb(1, ADDR_TRG_CTL, {24'h0, i[0], 7'h0}, 0);
      n0 = trig_cnt;
      n1 = sec_cnt;
      @(posedge pclk);
      sec_trig_event <= 1'b1;
      @(posedge pclk);
      sec_trig_event <= 1'b0;
      tick(4);
      chk("merged", n0 + i, trig_cnt);
      chk("separate", n1 + 1 - i, sec_cnt);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
